/* File: bench/spi_far_end.sv */
/*
  Far-end serial controller: clock idles low, capture on the active edge.
  Assumes the bench muxes the clock of both ends and calls frame as master.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_far_end (
  input  wire logic clk,
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  output logic      sck_m,
  output logic      ss_n
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;

  initial
  begin
    sck_m = 1'b0;
    ss_n = 1'b1;
    tx_q = 8'h00;
  end

  // Capture and shift on opposite edges so a sample never races its own shift.
  always @(sck)
  begin
    if (sck === 1'b1)
      rx_q <= {rx_q[6:0], mosi};
    else
      tx_q <= {tx_q[6:0], 1'b0};
  end

  assign miso = tx_q[7];

  // The clock stands still outside a frame, and select idles high.
  task automatic frame(input logic [7:0] b, input int n);
    tx_q = b;
    @(posedge clk);
    ss_n <= 1'b0;
    repeat (2 * n)
    begin
      repeat (4) @(posedge clk);
      sck_m <= ~sck_m;
    end
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* File: bench/spi_port_chk.sv */
/*
  Port-level checker of the serial port, bound to its top module.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_port_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        sdo_out,
  input wire logic        sdo_oe,
  input wire logic        sleep_mode,
  input wire logic        wake_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  reset_quiet_a: assert property ($rose(aresetn) |-> !sck_oe && !sdo_oe && !wake_request)
    else $error("pins or wake active after reset");
  sleep_sck_a: assert property (sleep_mode && sck_oe |=> $stable(sck_out))
    else $error("serial clock moved in sleep");
  sleep_sdo_a: assert property (sleep_mode && sck_oe && sdo_oe |=> $stable(sdo_out))
    else $error("data out moved in sleep");
  half_min_a: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out))
    else $error("serial clock half period too short");
  w_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  r_block_a: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  r_width_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  r_err_a: assert property (rvalid && rresp == spi_port_pkg::RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read carries data");
endmodule

bind spi_port_master_slave spi_port_chk chk_i (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready), .bvalid(bvalid),
  .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .sck_out(sck_out),
  .sck_oe(sck_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sleep_mode(sleep_mode),
  .wake_request(wake_request)
);

`default_nettype wire

/* File: bench/spi_port_master_slave_tb_top.sv */
/*
  Self-checking bench of the serial port: registers, master rates, sleep,
  receive-only master and slave framing. Assumes spi_far_end and the checker.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_port_master_slave_tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, sleep_mode, timer_two_tick, sck_out, sck_oe;
  logic        sdo_out, sdo_oe, wake_request, miso, sck_m, ss_n;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  hs;
  wire         sck_w = sck_oe ? sck_out : sck_m;
  wire         sdo_w = sdo_oe ? sdo_out : 1'bz;
  int          n_errors = 0, n_checks = 0, tick_n = 0;

  spi_port_master_slave dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(miso), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .ss_n_in(ss_n), .timer_two_tick(timer_two_tick), .sleep_mode(sleep_mode),
    .wake_request(wake_request)
  );
  spi_far_end far (.clk(aclk), .sck(sck_w), .mosi(sdo_w), .miso(miso), .sck_m(sck_m), .ss_n(ss_n));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // One timer pulse every third cycle gives a three-cycle half bit.
  always @(posedge aclk)
  begin
    tick_n <= (tick_n == 2) ? 0 : tick_n + 1;
    timer_two_tick <= (tick_n == 2);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // Handshakes are sampled mid-cycle, where the values equal those of the next edge.
  task automatic ax(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h000000, d};
    bready <= wr;
    rready <= !wr;
    n = 0;
    do
    begin
      @(negedge aclk);
      hs = {awready, wready, arready, wr ? bvalid : rvalid};
      rd = rdata;
      resp = wr ? bresp : rresp;
      @(posedge aclk);
      if (hs[3] === 1'b1)
        awvalid <= 1'b0;
      if (hs[2] === 1'b1)
        wvalid <= 1'b0;
      if (hs[1] === 1'b1)
        arvalid <= 1'b0;
      n++;
    end
    while (hs[0] !== 1'b1 && n < 99);
    bready <= 1'b0;
    rready <= 1'b0;
  endtask

  task automatic wake_wait;
    int n;
    for (n = 0; n < 2000 && wake_request !== 1'b1; n++)
      @(posedge aclk);
    chk("wake request", 32'h1, wake_request);
  endtask

  task automatic cfg(input logic [7:0] dir, input logic [7:0] ctl);
    ax(1'b1, spi_port_pkg::OFS_CONTROL, 8'h00);
    ax(1'b1, spi_port_pkg::OFS_DIRECTION, dir);
    ax(1'b1, spi_port_pkg::OFS_STATUS, 8'h40);
    ax(1'b1, spi_port_pkg::OFS_EVENT, 8'h03);
    ax(1'b1, spi_port_pkg::OFS_CONTROL, ctl);
  endtask

  task automatic t_regs;
    ax(1'b0, spi_port_pkg::OFS_CONTROL, 8'h00);
    chk("control reset", 32'h0, rd);
    ax(1'b0, spi_port_pkg::OFS_STATUS, 8'h00);
    chk("status reset", 32'h0, rd);
    ax(1'b0, spi_port_pkg::OFS_DIRECTION, 8'h00);
    chk("direction reset", 32'hFF, rd);
    ax(1'b0, 5'h14, 8'h00);
    chk("unmapped response", 32'h2, resp);
    $display("test registers done");
  endtask

  task automatic t_master;
    int m, t, k;
    logic p;
    for (m = 0; m < 4; m++)
    begin
      cfg((m == 2) ? 8'h30 : 8'h10, {4'h2, 4'(m)});
      far.tx_q = 8'h3C ^ m;
      ax(1'b1, spi_port_pkg::OFS_DATA, 8'hA5 ^ m);
      ax(1'b1, spi_port_pkg::OFS_DATA, 8'h00);
      t = 0;
      k = 0;
      p = sck_out;
      while (k < 2 && t < 300)
      begin
        @(negedge aclk);
        t++;
        if (sck_out !== p)
        begin
          k++;
          t = (k == 1) ? 0 : t;
        end
        p = sck_out;
      end
      chk("half period", (m == 3) ? 3 : (spi_port_pkg::BIT_DIV_4 << (2 * m)) / 2, t);
      chk("data out enable", m != 2, sdo_oe);
      if (m == 1)
      begin
        @(posedge aclk);
        sleep_mode <= 1'b1;
        repeat (40) @(posedge aclk);
        sleep_mode <= 1'b0;
      end
      wake_wait();
      ax(1'b0, spi_port_pkg::OFS_CONTROL, 8'h00);
      chk("collision", 32'h1, rd[7]);
      ax(1'b0, spi_port_pkg::OFS_STATUS, 8'h00);
      chk("buffer full", 32'h1, rd[0]);
      ax(1'b0, spi_port_pkg::OFS_DATA, 8'h00);
      chk("rx byte", 8'h3C ^ m, rd);
      ax(1'b0, spi_port_pkg::OFS_STATUS, 8'h00);
      chk("buffer full cleared", 32'h0, rd[0]);
      if (m != 2)
        chk("far rx", 8'hA5 ^ m, far.rx_q);
      $display("test master mode %0d done", m);
    end
  endtask

  task automatic t_slave;
    cfg(8'h18, {4'h2, spi_port_pkg::MODE_SLAVE_SS});
    chk("float deselected", 32'h0, sdo_oe);
    ax(1'b1, spi_port_pkg::OFS_DATA, 8'h96);
    sleep_mode <= 1'b1;
    far.frame(8'h5A, 3);
    chk("float on deselect", 32'h0, sdo_oe);
    ax(1'b1, spi_port_pkg::OFS_DATA, 8'h96);
    ax(1'b0, spi_port_pkg::OFS_CONTROL, 8'h00);
    chk("no collision", 32'h0, rd[7]);
    far.frame(8'h5A, 8);
    sleep_mode <= 1'b0;
    wake_wait();
    chk("far rx", 32'h96, far.rx_q);
    far.frame(8'hC3, 8);
    ax(1'b0, spi_port_pkg::OFS_CONTROL, 8'h00);
    chk("overflow", 32'h1, rd[6]);
    ax(1'b0, spi_port_pkg::OFS_DATA, 8'h00);
    chk("slave rx", 32'h5A, rd);
    $display("test slave done");
  endtask

  task automatic t_reset;
    cfg(8'h10, 8'h20);
    ax(1'b1, spi_port_pkg::OFS_DATA, 8'hC3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("clock drive after reset", 32'h0, sck_oe);
    ax(1'b0, spi_port_pkg::OFS_CONTROL, 8'h00);
    chk("control after reset", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_errors++;
    stop_test();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_mode, timer_two_tick} = 8'h00;
    {awaddr, araddr, wdata} = 42'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_master();
    t_slave();
    t_reset();
    stop_test();
  end
endmodule

`default_nettype wire

/* File: hdl/spi_port_master_slave.sv */
/*
  Byte-wide serial port, master or slave, with an AXI4-Lite register slave.
  Assumes every pin input is synchronous to aclk, the serial clock being sampled
  and edge-detected at aclk, so slave clocks must be well below aclk/4.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_port_master_slave (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [spi_port_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic [1:0]                         bresp,
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [spi_port_pkg::ADDR_W-1:0] araddr,
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  input  wire logic                          sck_in,
  output logic                               sck_out,
  output logic                               sck_oe,
  input  wire logic                          sdi_in,
  output logic                               sdo_out,
  output logic                               sdo_oe,
  input  wire logic                          ss_n_in,
  input  wire logic                          timer_two_tick,
  input  wire logic                          sleep_mode,
  output logic                               wake_request
);

  spi_port_pkg::state_s s_q;
  spi_port_pkg::state_s s_d;

  logic       en;
  logic       clock_idle_polarity;
  logic [3:0] mode;
  logic       master;
  logic       slave;
  logic       slave_sel;
  logic       busy_any;
  logic       wr_go;
  logic       rd_go;
  logic       data_wr;
  logic       tick;
  logic       cap;
  logic       sh;
  logic       sck_s;
  logic       to_active;
  logic       done;
  logic       ovf_set;
  logic       write_collision_flag_set;
  logic [4:0] term;
  logic [4:0] last;
  logic [7:0] rx_byte;

  // Every register sits in the low byte of its word; the upper bits always read zero.
  function automatic logic [7:0] read_reg(input spi_port_pkg::state_s s,
                                          input logic [spi_port_pkg::ADDR_W-1:0] a);
    case (a)
      spi_port_pkg::OFS_DATA:      read_reg = s.data_buf;
      spi_port_pkg::OFS_CONTROL:   read_reg = s.control;
      spi_port_pkg::OFS_STATUS:    read_reg = {s.input_sample_phase, s.cke, 5'h00, s.bf};
      spi_port_pkg::OFS_DIRECTION: read_reg = s.dir;
      spi_port_pkg::OFS_EVENT:     read_reg = {6'h00, s.done_en, s.done_flag};
      default:                     read_reg = 8'h00;
    endcase
  endfunction

  // Unmapped offsets answer with an error response and change nothing.
  function automatic logic mapped(input logic [spi_port_pkg::ADDR_W-1:0] a);
    mapped = (a == spi_port_pkg::OFS_DATA) || (a == spi_port_pkg::OFS_CONTROL)
          || (a == spi_port_pkg::OFS_STATUS) || (a == spi_port_pkg::OFS_DIRECTION)
          || (a == spi_port_pkg::OFS_EVENT);
  endfunction

  assign en     = s_q.control[spi_port_pkg::CTL_EN];
  assign clock_idle_polarity    = s_q.control[spi_port_pkg::CTL_CKP];
  assign mode   = s_q.control[3:0];
  // Codes above the two slave codes are reserved and leave the port inert.
  assign master = en && (mode <= spi_port_pkg::MODE_MASTER_TMR);
  assign slave  = en && ((mode == spi_port_pkg::MODE_SLAVE_SS)
                      || (mode == spi_port_pkg::MODE_SLAVE_FREE));

  // Select is honoured only in select-controlled slave mode with the pin set as input.
  assign slave_sel = (mode != spi_port_pkg::MODE_SLAVE_SS)
                  || !s_q.dir[spi_port_pkg::DIR_SS] || !ss_n_in;

  // A slave whose clock pin is made an output sees a clock parked at idle.
  assign sck_s     = s_q.dir[spi_port_pkg::DIR_SCK] ? sck_in : clock_idle_polarity;
  assign to_active = (sck_s != clock_idle_polarity);

  // Write address and data are parked in the state until both have arrived, so the
  // two channels may come in either order. The response rises together with the
  // commit, which puts the register update and bvalid in the same clock.
  assign awready = !s_q.aw_held && !s_q.bvalid;
  assign wready  = !s_q.w_held && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;
  assign rvalid  = s_q.rvalid;
  assign rdata   = {24'h000000, s_q.rdata};
  assign rresp   = s_q.rresp;

  // Both pin values are registered so the far end never sees a combinational glitch.
  assign sck_out = s_q.sck_q;
  assign sdo_out = s_q.tx[7];
  assign sck_oe  = master && !s_q.dir[spi_port_pkg::DIR_SCK];
  // Data out drops the moment select rises, even mid-byte.
  assign sdo_oe  = (master || (slave && slave_sel))
                && !s_q.dir[spi_port_pkg::DIR_SDO];
  assign wake_request = s_q.done_flag && s_q.done_en;

  always_comb
  begin
    s_d      = s_q;
    wr_go    = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    rd_go    = arvalid && !s_q.rvalid;
    data_wr  = wr_go && s_q.wstrb0 && (s_q.awaddr == spi_port_pkg::OFS_DATA);
    busy_any = master ? s_q.busy : (slave && (s_q.cnt != 3'h0));
    tick     = 1'b0;
    cap      = 1'b0;
    sh       = 1'b0;
    done     = 1'b0;
    ovf_set  = 1'b0;
    write_collision_flag_set = 1'b0;
    rx_byte  = s_q.byte_shifter;
    last     = (!s_q.cke && s_q.input_sample_phase) ? spi_port_pkg::EDGE_LAST_LATE : spi_port_pkg::EDGE_LAST;
    // The divider counts half bit periods from zero, so each term is one less than half the bit divisor.
    case (mode)
      spi_port_pkg::MODE_MASTER_DIV16: term = spi_port_pkg::HALF_TERM_16;
      spi_port_pkg::MODE_MASTER_DIV64: term = spi_port_pkg::HALF_TERM_64;
      default:                         term = spi_port_pkg::HALF_TERM_4;
    endcase

    if (awvalid && awready)
    begin
      s_d.aw_held = 1'b1;
      s_d.awaddr  = awaddr;
    end
    if (wvalid && wready)
    begin
      s_d.w_held = 1'b1;
      s_d.wdata  = wdata[7:0];
      s_d.wstrb0 = wstrb[0];
    end
    if (s_q.bvalid && bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && rready)
    begin
      s_d.rvalid = 1'b0;
    end

    if (wr_go)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = mapped(s_q.awaddr) ? spi_port_pkg::RESP_OKAY : spi_port_pkg::RESP_SLVERR;
      if (s_q.wstrb0)
      begin
        case (s_q.awaddr)
          spi_port_pkg::OFS_CONTROL:   s_d.control = s_q.wdata;
          spi_port_pkg::OFS_STATUS:
          begin
            s_d.input_sample_phase = s_q.wdata[spi_port_pkg::STS_SMP];
            s_d.cke = s_q.wdata[spi_port_pkg::STS_CKE];
          end
          spi_port_pkg::OFS_DIRECTION: s_d.dir = s_q.wdata;
          spi_port_pkg::OFS_EVENT:
          begin
            s_d.done_en = s_q.wdata[spi_port_pkg::EVT_EN];
            if (s_q.wdata[spi_port_pkg::EVT_DONE])
            begin
              s_d.done_flag = 1'b0;
            end
          end
          default:
          begin
          end
        endcase
      end
    end

    // A read of the data buffer empties it unless a new byte lands in the same
    // cycle; the hardware set further down then wins.
    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = read_reg(s_q, araddr);
      s_d.rresp  = mapped(araddr) ? spi_port_pkg::RESP_OKAY : spi_port_pkg::RESP_SLVERR;
      if (araddr == spi_port_pkg::OFS_DATA)
      begin
        s_d.bf = 1'b0;
      end
    end

    // A buffer write while a byte is in flight is dropped and flagged.
    if (data_wr && busy_any)
    begin
      write_collision_flag_set = 1'b1;
    end
    else if (data_wr)
    begin
      s_d.data_buf = s_q.wdata;
      s_d.tx       = s_q.wdata;
      if (master)
      begin
        s_d.busy   = 1'b1;
        s_d.edge_n = 5'h00;
        s_d.div    = 5'h00;
        s_d.sck_q  = clock_idle_polarity;
      end
    end

    // The divider and edge counter only advance outside sleep, so sleep simply stops them
    // and the transfer resumes on the very edge where it stopped.
    // In timer mode each timer pulse is one half bit, giving a bit of two pulses.
    if (master && s_q.busy && !sleep_mode)
    begin
      tick = (mode == spi_port_pkg::MODE_MASTER_TMR) ? timer_two_tick : (s_q.div == term);
      s_d.div = tick ? 5'h00 : 5'(s_q.div + 5'h01);
      if (tick)
      begin
        // Capture edges alternate with shift edges; a late sample phase moves capture one half.
        cap = (s_q.edge_n[0] == (!s_q.cke ^ s_q.input_sample_phase))
           && !((s_q.edge_n == 5'h00) && !s_q.cke && s_q.input_sample_phase);
        sh  = (s_q.edge_n[0] == s_q.cke) && (s_q.edge_n != 5'h00)
           && (s_q.edge_n < spi_port_pkg::EDGE_LAST);
        if (cap)
        begin
          s_d.byte_shifter = {s_q.byte_shifter[6:0], sdi_in};
        end
        if (sh)
        begin
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end
        if (s_q.edge_n < spi_port_pkg::EDGE_LAST_LATE)
        begin
          s_d.sck_q = !s_q.sck_q;
        end
        s_d.edge_n = 5'(s_q.edge_n + 5'h01);
        if (s_q.edge_n == last)
        begin
          s_d.busy = 1'b0;
          done     = 1'b1;
          rx_byte  = s_d.byte_shifter;
        end
      end
    end
    else if (!master)
    begin
      s_d.busy  = 1'b0;
      s_d.sck_q = clock_idle_polarity;
    end

    // Slave logic ignores sleep so a byte can arrive and wake the core.
    s_d.sck_prev = sck_s;
    if (slave && !slave_sel)
    begin
      s_d.cnt = 3'h0;
    end
    else if (slave && (sck_s != s_q.sck_prev))
    begin
      if (to_active == s_q.cke)
      begin
        s_d.byte_shifter = {s_q.byte_shifter[6:0], sdi_in};
        s_d.cnt          = 3'(s_q.cnt + 3'h1);
        if (s_q.cnt == spi_port_pkg::BIT_LAST)
        begin
          s_d.cnt = 3'h0;
          done    = 1'b1;
          rx_byte = s_d.byte_shifter;
          ovf_set = s_q.bf;
        end
      end
      // A shift edge seen before any capture would lose the first bit, so it is
      // ignored while the bit count is still zero.
      else if (s_q.cnt != 3'h0)
      begin
        s_d.tx = {s_q.tx[6:0], 1'b0};
      end
    end

    // Clearing the enable aborts whatever is in flight; the buffer and flags are kept
    // so software can still read what arrived before.
    if (!en)
    begin
      s_d.busy   = 1'b0;
      s_d.cnt    = 3'h0;
      s_d.edge_n = 5'h00;
      s_d.sck_q  = clock_idle_polarity;
    end

    // Hardware sets win over a clear in the same cycle.
    // A byte that completes while the buffer is still full is dropped but still raises the
    // done flag and the overflow flag; a master never does this because ovf_set stays low there.
    if (done)
    begin
      s_d.done_flag = 1'b1;
      s_d.bf        = 1'b1;
      if (!ovf_set)
      begin
        s_d.data_buf = rx_byte;
      end
    end
    if (ovf_set)
    begin
      s_d.control[spi_port_pkg::CTL_OVF] = 1'b1;
    end
    if (write_collision_flag_set)
    begin
      s_d.control[spi_port_pkg::CTL_WRITE_COLLISION_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // The data buffer needs no particular reset value, yet clearing it keeps the
      // first read free of unknowns.
      s_q         <= '0;
      s_q.control <= spi_port_pkg::CONTROL_RST;
      s_q.dir     <= spi_port_pkg::DIRECTION_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/spi_port_pkg.sv */
/*
  Constants, register map and state record for the byte-wide serial port.
  Assumes a single 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package spi_port_pkg;

  localparam int ADDR_W = 5;

  localparam logic [4:0] OFS_DATA      = 5'h00;
  localparam logic [4:0] OFS_CONTROL   = 5'h04;
  localparam logic [4:0] OFS_STATUS    = 5'h08;
  localparam logic [4:0] OFS_DIRECTION = 5'h0C;
  localparam logic [4:0] OFS_EVENT     = 5'h10;

  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OVF  = 6;
  localparam int CTL_EN   = 5;
  localparam int CTL_CKP  = 4;
  localparam int STS_SMP  = 7;
  localparam int STS_CKE  = 6;
  localparam int STS_BF   = 0;
  localparam int DIR_SDO  = 5;
  localparam int DIR_SS   = 4;
  localparam int DIR_SCK  = 3;
  localparam int EVT_DONE = 0;
  localparam int EVT_EN   = 1;

  localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TMR   = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SS     = 4'h4;
  localparam logic [3:0] MODE_SLAVE_FREE   = 4'h5;

  localparam logic [7:0] CONTROL_RST   = 8'h00;
  localparam logic [7:0] DIRECTION_RST = 8'hFF;

  // Bit periods in system clocks; the divider counts half periods.
  localparam int         BIT_DIV_4   = 4;
  localparam int         BIT_DIV_16  = 16;
  localparam int         BIT_DIV_64  = 64;
  localparam logic [4:0] HALF_TERM_4  = 5'(BIT_DIV_4 / 2 - 1);
  localparam logic [4:0] HALF_TERM_16 = 5'(BIT_DIV_16 / 2 - 1);
  localparam logic [4:0] HALF_TERM_64 = 5'(BIT_DIV_64 / 2 - 1);

  localparam logic [4:0] EDGE_LAST      = 5'h0F;
  localparam logic [4:0] EDGE_LAST_LATE = 5'h10;
  localparam logic [2:0] BIT_LAST       = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [7:0]        wdata;
    logic              wstrb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [7:0]        data_buf;
    logic [7:0]        control;
    logic              input_sample_phase;
    logic              cke;
    logic              bf;
    logic [7:0]        dir;
    logic              done_flag;
    logic              done_en;
    logic              busy;
    logic [7:0]        tx;
    logic [7:0]        byte_shifter;
    logic [2:0]        cnt;
    logic [4:0]        edge_n;
    logic [4:0]        div;
    logic              sck_q;
    logic              sck_prev;
  } state_s;

endpackage
